/* File: hdl/jrf_consts.svh */
/*
 * named constants of the lane receiver front: register map, field
 * positions, reset values, control characters and link limits.
 * assumes it is included by bare name wherever a number is needed.
 */
`ifndef JRF_CONSTS_SVH
`define JRF_CONSTS_SVH

// =====================================================================
// register map (byte addresses, 32-bit words)
`define JRF_ADR_CTRL      8'h00
`define JRF_ADR_STAT      8'h04
`define JRF_ADR_IRQ_ST    8'h08
`define JRF_ADR_IRQ_MSK   8'h0c
`define JRF_CTRL_RST      32'h0000_0403
`define JRF_CTRL_K        4:0
`define JRF_CTRL_F        15:8
`define JRF_STAT_ALL      8
`define JRF_STAT_KF_BAD   16
`define JRF_STAT_MEM_BAD  17
`define JRF_STAT_IN_RST   18
`define JRF_NEV           3
`define JRF_EV_DATA       0
`define JRF_EV_ALIGN      1
`define JRF_EV_LCFG       2

// =====================================================================
// control characters and link limits
`define JRF_K_COMMA       8'hbc
`define JRF_K_FRAME       8'hfc
`define JRF_K_MFRAME      8'h7c
`define JRF_CGS_COMMAS    3'h4
`define JRF_K_MIN         6'h04
`define JRF_F_MIN         9'h002
`define JRF_MF_MIN        14'h0012
`define JRF_MF_MAX        14'h0400
`define JRF_FABRIC_MAX    14'h0014
`define JRF_CFG_MF        9'h001
`define JRF_CFG_FIRST     14'h0002
`define JRF_CFG_LAST      14'h000f
`define JRF_CFG_OCTETS    14

`endif

/* File: hdl/jrf_pkg.sv */
/*
 * types of the lane receiver front.
 * assumes nothing of its surroundings.
 */
package jrf_pkg;
   // one received octet with its control flag
   typedef struct packed {
      logic       k;
      logic [7:0] d;
   } jrf_oct_t;

   // per-lane alignment progress
   typedef enum logic [1:0] {
      code_sync_st,
      initial_alignment_state,
      data_phase_state
   } jrf_lane_st_t;
endpackage

/* File: hdl/jrf_lane_receiver_front.sv */
/*
 * lane receiver front: lane input capture, optional symbol decoding,
 * code group sync, initial lane alignment, frame alignment repair,
 * link configuration checksum, word assembly, wishbone registers.
 * assumes one clock clk_i, lane pins asynchronous to it, lane 0 clock
 * slower than clk_i by a wide margin (at least 12 clk_i per period).
 */
// Functional notes
// - frame alignment repair present when FRAME_FIX is 1, absent when 0.
// - memory select 0 fabric only for K*F<=20, 1 small RAM, 2 large RAM.
// - checksum sums whole fields for method 0, configuration octets for 1.
// - mode 1 takes (width/8)*10 bits; mode 2 takes 10 or 8 bits.
// - in mode 2 the core word rate is slower than the lane clock.
// - link configuration check present only when LINK_CHECK is 1.
// - user words are 16, 32 or 64 bits for width select 0, 1, 2.
// - internal symbol decoder when DECODER_EN is 1, decoded octets when 0.
// - alignment length equals transmitter's and ends initial alignment state.
// - multiframe is K frames of F octets, 18 to 1024 octets in total.
// - active-low reset through a synchronizer; held three core cycles.
// - lane valid inputs join the reset before synchronizing.
// - without decoder, octet plus flag per lane, widened per octet in mode 1.
// - without decoder a receiver channel reset output is driven.
// - active lanes equal the lane count parameter plus one.
`timescale 1ns/10ps
`include "jrf_consts.svh"
`default_nettype none

module jrf_lane_receiver_front #(
   parameter int      LANE_PARAM      = 0,
   parameter int      WIDTH_SEL       = 0,
   parameter int      INPUT_MODE      = 1,
   parameter int      DECODER_EN      = 1,
   parameter int      FRAME_FIX       = 1,
   parameter int      MEM_SELECT      = 0,
   parameter int      CHECKSUM_OCTETS = 1,
   parameter int      LINK_CHECK      = 1,
   parameter int      ALIGN_MF_COUNT  = 4,
   localparam int     LANES           = LANE_PARAM + 1,
   localparam int     NB              = 2 << WIDTH_SEL,
   localparam int     DW              = 8 * NB,
   localparam int     SW              = 10 * NB
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   input  wire logic [3:0]            wb_sel_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   output logic                       irq_o,
   input  wire logic                  core_reset_n_i,
   input  wire logic                  lane0_receive_clock_i,
   input  wire logic [LANES-1:0]      lane_receive_valid_i,
   input  wire logic [LANES*SW-1:0]   lane_raw_symbols_i,
   input  wire logic [LANES*DW-1:0]   lane_octets_i,
   input  wire logic [LANES*NB-1:0]   lane_octet_is_ctrl_i,
   output logic      [LANES*DW-1:0]   lane_data_o,
   output logic      [LANES-1:0]      lane_data_valid_o,
   output logic                       lane_rx_reset_n_o
);
   import jrf_pkg::*;

   localparam int IW = LANES * (SW + DW + NB);

   // =====================================================================
   // helpers
   // 10-bit symbol to octet; unknown 6-bit groups read as low five bits zero, unknown 4-bit groups as high three bits 7
   function automatic jrf_oct_t dec10(input logic [9:0] s);
      logic [5:0] a;
      logic [3:0] f;
      logic [4:0] x;
      logic [2:0] y;
      logic       k;
      a = s[9:4];
      f = s[3:0];
      k = (a == 6'b001111) || (a == 6'b110000);
      if (a == 6'b110000) begin
         f = ~f;
      end
      case (a)
         6'b100111, 6'b011000: x = 5'd0;
         6'b011101, 6'b100010: x = 5'd1;
         6'b101101, 6'b010010: x = 5'd2;
         6'b110001:            x = 5'd3;
         6'b110101, 6'b001010: x = 5'd4;
         6'b101001:            x = 5'd5;
         6'b011001:            x = 5'd6;
         6'b111000, 6'b000111: x = 5'd7;
         6'b111001, 6'b000110: x = 5'd8;
         6'b100101:            x = 5'd9;
         6'b010101:            x = 5'd10;
         6'b110100:            x = 5'd11;
         6'b001101:            x = 5'd12;
         6'b101100:            x = 5'd13;
         6'b011100:            x = 5'd14;
         6'b010111, 6'b101000: x = 5'd15;
         6'b011011, 6'b100100: x = 5'd16;
         6'b100011:            x = 5'd17;
         6'b010011:            x = 5'd18;
         6'b110010:            x = 5'd19;
         6'b001011:            x = 5'd20;
         6'b101010:            x = 5'd21;
         6'b011010:            x = 5'd22;
         6'b111010, 6'b000101: x = 5'd23;
         6'b110011, 6'b001100: x = 5'd24;
         6'b100110:            x = 5'd25;
         6'b010110:            x = 5'd26;
         6'b110110, 6'b001001: x = 5'd27;
         6'b001110, 6'b001111, 6'b110000: x = 5'd28;
         6'b101110, 6'b010001: x = 5'd29;
         6'b011110, 6'b100001: x = 5'd30;
         6'b101011, 6'b010100: x = 5'd31;
         default:              x = 5'd0;
      endcase
      case (f)
         4'b1011, 4'b0100: y = 3'd0;
         4'b1001:          y = 3'd1;
         4'b0101:          y = 3'd2;
         4'b1100, 4'b0011: y = 3'd3;
         4'b1101, 4'b0010: y = 3'd4;
         4'b1010:          y = 3'd5;
         4'b0110:          y = 3'd6;
         default:          y = 3'd7;
      endcase
      return '{k: k, d: {y, x}};
   endfunction

   // checksum over the captured configuration octets
   function automatic logic [7:0] csum(input logic [8*`JRF_CFG_OCTETS-1:0] c);
      logic [7:0] o [`JRF_CFG_OCTETS];
      logic [7:0] s;
      for (int i = 0; i < `JRF_CFG_OCTETS; i++) begin
         o[i] = c[8*(`JRF_CFG_OCTETS-1-i) +: 8];
      end
      s = 8'h00;
      if (CHECKSUM_OCTETS != 0) begin
         for (int i = 0; i < `JRF_CFG_OCTETS - 3; i++) begin
            s = s + o[i];
         end
      end else begin
         s = o[0] + {4'h0, o[1][3:0]} + {4'h0, o[1][7:4]} + {3'h0, o[2][4:0]}
           + {7'h0, o[2][5]} + {7'h0, o[2][6]} + {3'h0, o[3][4:0]} + {7'h0, o[3][7]}
           + o[4] + {3'h0, o[5][4:0]} + o[6] + {3'h0, o[7][4:0]} + {6'h0, o[7][7:6]}
           + {3'h0, o[8][4:0]} + {5'h0, o[8][7:5]} + {3'h0, o[9][4:0]}
           + {5'h0, o[9][7:5]} + {3'h0, o[10][4:0]} + {7'h0, o[10][7]};
      end
      return s;
   endfunction

   // byte enables to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // =====================================================================
   // synchronizers: reset, lane 0 clock, lane pins
   logic [2:0]    rs_q, rs_d, ck_q, ck_d;
   logic          rhold_q, rhold_d, lvl_q, lvl_d;
   logic [IW-1:0] ip_q [3];
   logic          core_rst, rise;

   // reset and clock levels count once stages two and three agree
   always_comb begin
      rs_d    = {rs_q[1:0], core_reset_n_i & (&lane_receive_valid_i)};
      ck_d    = {ck_q[1:0], lane0_receive_clock_i};
      rhold_d = (rs_q[1] == rs_q[2]) ? rs_q[2] : rhold_q;
      lvl_d   = (ck_q[1] == ck_q[2]) ? ck_q[2] : lvl_q;
   end

   assign core_rst = rst_i | ~rhold_q;
   assign rise     = ck_q[1] & ck_q[2] & ~lvl_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rs_q    <= 3'h0;
         ck_q    <= 3'h0;
         rhold_q <= 1'b0;
         lvl_q   <= 1'b0;
      end else begin
         rs_q    <= rs_d;
         ck_q    <= ck_d;
         rhold_q <= rhold_d;
         lvl_q   <= lvl_d;
      end
   end

   // lane pins follow the clock through matching stages, no reset needed
   always_ff @(posedge clk_i) begin
      ip_q[0] <= {lane_octet_is_ctrl_i, lane_octets_i, lane_raw_symbols_i};
      ip_q[1] <= ip_q[0];
      ip_q[2] <= ip_q[1];
   end

   // =====================================================================
   // link geometry from the control register
   logic [31:0] ctrl_q, ctrl_d;
   logic [5:0]  ksz;
   logic [8:0]  fsz;
   logic [13:0] kf;
   logic        kf_bad, mem_bad;

   always_comb begin
      ksz     = {1'b0, ctrl_q[`JRF_CTRL_K]} + 6'h01;
      fsz     = {1'b0, ctrl_q[`JRF_CTRL_F]} + 9'h001;
      kf      = 14'(ksz) * 14'(fsz);
      kf_bad  = (ksz < `JRF_K_MIN) || (fsz < `JRF_F_MIN)
             || (kf < `JRF_MF_MIN) || (kf > `JRF_MF_MAX);
      mem_bad = (MEM_SELECT > 2) || ((MEM_SELECT == 0) && (kf > `JRF_FABRIC_MAX));
   end

   // =====================================================================
   // per-lane alignment
   logic [LANES-1:0] ev_data, ev_align, ev_lcfg, in_data;

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      jrf_oct_t [NB-1:0]           fq_q, fq_d;
      logic [3:0]                  fc_q, fc_d;
      jrf_lane_st_t                st_q, st_d;
      logic [2:0]                  cc_q, cc_d, wc_q, wc_d;
      logic [7:0]                  po_q, po_d;
      logic [4:0]                  pf_q, pf_d;
      logic [8:0]                  mf_q, mf_d;
      logic [8*`JRF_CFG_OCTETS-1:0] cfg_q, cfg_d;
      logic [DW-1:0]               wb_q, wb_d, dat_q, dat_d;
      logic                        vld_q, vld_d, chk_q, chk_d;
      logic                        evd_q, evd_d, eva_q, eva_d, evl_q, evl_d;
      jrf_oct_t                    cur;
      logic                        last_o, last_f;
      logic [13:0]                 moct;

      always_comb begin
         fq_d   = fq_q;
         fc_d   = fc_q;
         st_d   = st_q;
         cc_d   = cc_q;
         po_d   = po_q;
         pf_d   = pf_q;
         mf_d   = mf_q;
         cfg_d  = cfg_q;
         wb_d   = wb_q;
         wc_d   = wc_q;
         dat_d  = dat_q;
         vld_d  = 1'b0;
         chk_d  = 1'b0;
         evd_d  = 1'b0;
         eva_d  = 1'b0;
         evl_d  = 1'b0;
         cur    = fq_q[0];
         last_o = (po_q == ctrl_q[`JRF_CTRL_F]);
         last_f = (pf_q == ctrl_q[`JRF_CTRL_K]);
         moct   = 14'(pf_q) * 14'(fsz) + 14'(po_q);
         // octets drain one per clk; the lane clock is far slower
         if (fc_q != 4'h0) begin
            fq_d = fq_q >> $bits(jrf_oct_t);
            fc_d = fc_q - 4'h1;
         end
         // mode 1 loads a whole word, mode 2 a single symbol
         // mode 2 thus gives one core word per NB lane clocks
         if (rise) begin
            for (int j = 0; j < NB; j++) begin
               if (INPUT_MODE == 1 || j == 0) begin
                  fq_d[j] = (DECODER_EN != 0)
                     ? dec10(ip_q[2][l*SW + 10*j +: 10])
                     : '{k: ip_q[2][LANES*(SW+DW) + l*NB + j],
                         d: ip_q[2][LANES*SW + l*DW + 8*j +: 8]};
               end
            end
            fc_d = (INPUT_MODE == 1) ? 4'(NB) : 4'h1;
         end
         if (fc_q != 4'h0) begin
            case (st_q)
               code_sync_st: begin
                  if (cur.k && cur.d == `JRF_K_COMMA) begin
                     cc_d = (cc_q == `JRF_CGS_COMMAS) ? cc_q : cc_q + 3'h1;
                  end else if (cc_q == `JRF_CGS_COMMAS && !kf_bad) begin
                     st_d = initial_alignment_state;
                     po_d = 8'h01;
                     pf_d = 5'h00;
                     mf_d = 9'h000;
                  end else begin
                     cc_d = 3'h0;
                  end
               end
               initial_alignment_state: begin
                  // configuration octets follow the two markers of multiframe 1
                  if (LINK_CHECK != 0 && mf_q == `JRF_CFG_MF
                      && moct >= `JRF_CFG_FIRST && moct <= `JRF_CFG_LAST) begin
                     cfg_d = {cfg_q[8*`JRF_CFG_OCTETS-9:0], cur.d};
                     chk_d = (moct == `JRF_CFG_LAST);
                  end
                  po_d = last_o ? 8'h00 : po_q + 8'h01;
                  if (last_o) begin
                     pf_d = last_f ? 5'h00 : pf_q + 5'h01;
                  end
                  if (last_o && last_f) begin
                     if (mf_q == 9'(ALIGN_MF_COUNT - 1)) begin
                        st_d  = data_phase_state;
                        evd_d = 1'b1;
                        wc_d  = 3'h0;
                     end else begin
                        mf_d = mf_q + 9'h001;
                     end
                  end
               end
               data_phase_state: begin
                  // a frame marker away from the frame end means we slipped
                  if (FRAME_FIX != 0 && cur.k && !last_o
                      && (cur.d == `JRF_K_FRAME || cur.d == `JRF_K_MFRAME)) begin
                     po_d  = 8'h00;
                     pf_d  = last_f ? 5'h00 : pf_q + 5'h01;
                     eva_d = 1'b1;
                  end else begin
                     po_d = last_o ? 8'h00 : po_q + 8'h01;
                     if (last_o) begin
                        pf_d = last_f ? 5'h00 : pf_q + 5'h01;
                     end
                  end
                  // first octet ends up in the low byte
                  wb_d = {cur.d, wb_q[DW-1:8]};
                  wc_d = wc_q + 3'h1;
                  if (wc_q == 3'(NB - 1)) begin
                     dat_d = wb_d;
                     vld_d = 1'b1;
                     wc_d  = 3'h0;
                  end
               end
               default: st_d = code_sync_st;
            endcase
         end
         // checksum is judged the cycle after the last octet lands
         if (LINK_CHECK != 0 && chk_q && csum(cfg_q) != cfg_q[7:0]) begin
            evl_d = 1'b1;
         end
         if (kf_bad) begin
            st_d = code_sync_st;
            cc_d = 3'h0;
         end
      end

      // core reset returns the lane to comma search
      always_ff @(posedge clk_i) begin
         if (core_rst) begin
            fq_q  <= '0;
            fc_q  <= 4'h0;
            st_q  <= code_sync_st;
            cc_q  <= 3'h0;
            po_q  <= 8'h00;
            pf_q  <= 5'h00;
            mf_q  <= 9'h000;
            cfg_q <= '0;
            wb_q  <= '0;
            wc_q  <= 3'h0;
            dat_q <= '0;
            vld_q <= 1'b0;
            chk_q <= 1'b0;
            evd_q <= 1'b0;
            eva_q <= 1'b0;
            evl_q <= 1'b0;
         end else begin
            fq_q  <= fq_d;
            fc_q  <= fc_d;
            st_q  <= st_d;
            cc_q  <= cc_d;
            po_q  <= po_d;
            pf_q  <= pf_d;
            mf_q  <= mf_d;
            cfg_q <= cfg_d;
            wb_q  <= wb_d;
            wc_q  <= wc_d;
            dat_q <= dat_d;
            vld_q <= vld_d;
            chk_q <= chk_d;
            evd_q <= evd_d;
            eva_q <= eva_d;
            evl_q <= evl_d;
         end
      end

      assign lane_data_o[l*DW +: DW] = dat_q;
      assign lane_data_valid_o[l]    = vld_q;
      assign ev_data[l]              = evd_q;
      assign ev_align[l]             = eva_q;
      assign ev_lcfg[l]              = evl_q;
      assign in_data[l]              = (st_q == data_phase_state);
   end

   // =====================================================================
   // wishbone slave, interrupts, channel reset
   logic [31:0]         dat_q, dat_d, stat;
   logic [`JRF_NEV-1:0] ist_q, ist_d, msk_q, msk_d, ev;
   logic                ack_q, ack_d, irq_q, irq_d, wr, rxr_q, rxr_d;

   // answer one cycle after the request; writes land with the ack
   always_comb begin
      ev                    = {|ev_lcfg, |ev_align, |ev_data};
      stat                  = 32'h0000_0000;
      stat[LANES-1:0]       = in_data;
      stat[`JRF_STAT_ALL]   = &in_data;
      stat[`JRF_STAT_KF_BAD]  = kf_bad;
      stat[`JRF_STAT_MEM_BAD] = mem_bad;
      stat[`JRF_STAT_IN_RST]  = core_rst;
      ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
      wr     = ack_d & wb_we_i;
      ctrl_d = ctrl_q;
      msk_d  = msk_q;
      ist_d  = ist_q;
      dat_d  = dat_q;
      if (wr && wb_adr_i == `JRF_ADR_CTRL) begin
         ctrl_d = (ctrl_q & ~be_mask(wb_sel_i)) | (wb_dat_i & be_mask(wb_sel_i));
      end
      if (wr && wb_adr_i == `JRF_ADR_IRQ_MSK) begin
         msk_d = (msk_q & ~{`JRF_NEV{wb_sel_i[0]}}) | (wb_dat_i[`JRF_NEV-1:0] & {`JRF_NEV{wb_sel_i[0]}});
      end
      // a new event beats a clear in the same cycle
      if (wr && wb_adr_i == `JRF_ADR_IRQ_ST) begin
         ist_d = ist_q & ~(wb_dat_i[`JRF_NEV-1:0] & {`JRF_NEV{wb_sel_i[0]}});
      end
      ist_d = ist_d | ev;
      if (ack_d) begin
         case (wb_adr_i)
            `JRF_ADR_CTRL:    dat_d = ctrl_q;
            `JRF_ADR_STAT:    dat_d = stat;
            `JRF_ADR_IRQ_ST:  dat_d = {{(32-`JRF_NEV){1'b0}}, ist_q};
            `JRF_ADR_IRQ_MSK: dat_d = {{(32-`JRF_NEV){1'b0}}, msk_q};
            default:          dat_d = 32'h0000_0000;
         endcase
      end
      irq_d = |(ist_q & msk_q);
      rxr_d = (DECODER_EN == 0) ? ~core_rst : 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `JRF_CTRL_RST;
         msk_q  <= '0;
         ist_q  <= '0;
         dat_q  <= 32'h0000_0000;
         ack_q  <= 1'b0;
         irq_q  <= 1'b0;
         rxr_q  <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         msk_q  <= msk_d;
         ist_q  <= ist_d;
         dat_q  <= dat_d;
         ack_q  <= ack_d;
         irq_q  <= irq_d;
         rxr_q  <= rxr_d;
      end
   end

   assign wb_dat_o          = dat_q;
   assign wb_ack_o          = ack_q;
   assign irq_o             = irq_q;
   assign lane_rx_reset_n_o = rxr_q;
endmodule

`default_nettype wire

/* File: verification/jrf_front_sva.sv */
/* port checker of the lane receiver front.
   bound from the bench top; one clock, sync reset, one lane, 2-octet words. */
`timescale 1ns/10ps
`include "jrf_consts.svh"
`default_nettype none
module jrf_front_sva (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic        core_reset_n_i,
   input wire logic [0:0]  lane_receive_valid_i,
   input wire logic [15:0] lane_data_o,
   input wire logic [0:0]  lane_data_valid_o,
   input wire logic        lane_rx_reset_n_o
);
   // ==========================================
   // bus and lane relations
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
   mask_off_a: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == `JRF_ADR_IRQ_MSK
      && wb_dat_i == 32'h0000_0000 && wb_sel_i == 4'hf) |=> !irq_o) else $error("irq while masked");
   core_reset_a: assert property (!core_reset_n_i [*7] |-> !lane_rx_reset_n_o)
      else $error("channel reset not driven");
   valid_reset_a: assert property (!lane_receive_valid_i[0] [*7] |-> !lane_rx_reset_n_o
      && !lane_data_valid_o[0]) else $error("valid low left core running");
   word_gap_a: assert property (lane_data_valid_o[0] |=> !lane_data_valid_o[0])
      else $error("word pulse too long");
   word_hold_a: assert property (lane_rx_reset_n_o && $past(lane_rx_reset_n_o) && !lane_data_valid_o[0]
      |-> $stable(lane_data_o)) else $error("word changed without pulse");
endmodule
`default_nettype wire

/* File: verification/jrf_lane_src.sv */
/* far side model: transceiver with its decoder on, giving octets with
   control flags, one 2-octet word per lane clock; paced by the core clock. */
`timescale 1ns/10ps
`default_nettype none
module jrf_lane_src (
   input  wire logic  clk_i,
   output logic       lane_clk_o,
   output logic [15:0] oct_o,
   output logic [1:0]  kf_o
);
   // ==========================================
   // idle: clock stands still between words
   initial begin
      lane_clk_o = 1'b0;
      oct_o      = 16'h0000;
      kf_o       = 2'b00;
   end
   // 5 cycles set-up, 6 high; data garbled once its hold has run out
   task automatic send(input logic [15:0] d, input logic [1:0] k);
      @(posedge clk_i);
      oct_o <= d;
      kf_o  <= k;
      repeat (5) @(posedge clk_i);
      lane_clk_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      lane_clk_o <= 1'b0;
      oct_o      <= ~d;
      kf_o       <= ~k;
   endtask
endmodule
`default_nettype wire

/* File: verification/jrf_lane_receiver_front_tb.sv */
/* bench of the lane receiver front: wishbone tasks, lane source model,
   bound port checker. assumes package, header and design compiled first. */
`timescale 1ns/10ps
`include "jrf_consts.svh"
`default_nettype none
module jrf_lane_receiver_front_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic        rst_n = 1'b1;
   logic        val   = 1'b1;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] dat   = 32'h0000_0000;
   logic [31:0] rdat;
   wire  [31:0] dout;
   wire         ack, irq, lclk, rxrn;
   wire  [15:0] oct, ldat;
   wire  [1:0]  kf;
   wire  [0:0]  lval;
   logic [15:0] seen_q[$];
   int          failures = 0;
   int          checked  = 0;
   int          i;
   // ==========================================
   // clock, design, far side
   always #2 clk_i = ~clk_i;
   // raw symbols tied low, decoder removed; lane 0 clock from the model
   // with the decoder in, octets and flags would be tied low instead
   jrf_lane_receiver_front #(.DECODER_EN(0)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(dout),
      .wb_ack_o(ack), .irq_o(irq), .core_reset_n_i(rst_n), .lane0_receive_clock_i(lclk),
      .lane_receive_valid_i(val), .lane_raw_symbols_i(20'h0_0000), .lane_octets_i(oct),
      .lane_octet_is_ctrl_i(kf), .lane_data_o(ldat), .lane_data_valid_o(lval), .lane_rx_reset_n_o(rxrn));
   jrf_lane_src src (.clk_i(clk_i), .lane_clk_o(lclk), .oct_o(oct), .kf_o(kf));
   // words as they leave the front
   always @(posedge clk_i) if (lval[0] === 1'b1) seen_q.push_back(ldat);
   // ==========================================
   // tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dout;
      cyc <= 1'b0;
      if (n >= 20) begin
         failures++;
         complete_run();
      end
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      wb(1'b0, a, 32'h0000_0000);
      check(nm, rdat, exp);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`JRF_ADR_CTRL, `JRF_CTRL_RST, "ctrl");
      rd(`JRF_ADR_IRQ_MSK, 32'h0000_0000, "mask");
      wb(1'b1, 8'h10, 32'hffff_ffff);
      rd(8'h10, 32'h0000_0000, "unmapped");
      wb(1'b1, `JRF_ADR_STAT, 32'hffff_ffff);
      rd(`JRF_ADR_STAT, 32'h0000_0000, "stat ro");
      wb(1'b1, `JRF_ADR_CTRL, 32'h0000_0400);
      rd(`JRF_ADR_STAT, 32'h0001_0000, "stat kf bad");
      wb(1'b1, `JRF_ADR_CTRL, `JRF_CTRL_RST);
      $display("test registers done");
      // pin reset, then a dropped lane valid, each held 8 cycles
      for (i = 0; i < 2; i++) begin
         rst_n <= i[0];
         val   <= ~i[0];
         repeat (8) @(posedge clk_i);
         rd(`JRF_ADR_STAT, 32'h0004_0000, "stat core reset");
      end
      val <= 1'b1;
      repeat (8) @(posedge clk_i);
      $display("test reset done");
      wb(1'b1, `JRF_ADR_IRQ_MSK, 32'h0000_0001);
      // commas, four multiframes of 4x5 octets, then four data words;
      // word 17 closes the multiframe 1 config with a wrong checksum octet
      repeat (4) src.send(16'hbcbc, 2'b11);
      for (i = 0; i < 40; i++) src.send((i == 17) ? 16'h0100 : 16'h0000, 2'b00);
      for (i = 1; i < 5; i++) src.send(16'(i * 32'h0000_0201), 2'b00);
      repeat (20) @(posedge clk_i);
      rd(`JRF_ADR_STAT, 32'h0000_0101, "stat data");
      check("irq", 32'(irq), 32'h0000_0001);
      check("words", seen_q.size(), 4);
      for (i = 1; i < 5; i++) check("word", 32'(seen_q.pop_front()), i * 32'h0000_0201);
      $display("test link done");
      // frame marker at octet 3 of a frame forces a realign
      src.send(16'h00fc, 2'b01);
      repeat (20) @(posedge clk_i);
      rd(`JRF_ADR_IRQ_ST, 32'h0000_0007, "irq status");
      // masking alone must drop the line while status bits still stand
      wb(1'b1, `JRF_ADR_IRQ_MSK, 32'h0000_0000);
      check("irq off", 32'(irq), 32'h0000_0000);
      wb(1'b1, `JRF_ADR_IRQ_ST, 32'h0000_0007);
      rd(`JRF_ADR_IRQ_ST, 32'h0000_0000, "irq cleared");
      $display("test events done");
      complete_run();
   end
endmodule
bind jrf_lane_receiver_front jrf_front_sva chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_i, .wb_sel_i, .wb_ack_o, .irq_o, .core_reset_n_i, .lane_receive_valid_i, .lane_data_o,
   .lane_data_valid_o, .lane_rx_reset_n_o);
`default_nettype wire
